// [lcd_power_mgmt_pins.sv]
// power-management pin logic: status outputs, bus sleep gating, panel power sequencing
//
// Operation
// - general level output follows output level bit 7 of control byte.
// - standby status low exactly while in standby mode.
// - suspend status low exactly while in suspend mode.
// - bus sleep low disables memory and io interfaces.
// - after sleep goes low, no chip access until it returns high.
// - slow clock input times suspend refresh and panel sequencing.
// - three outputs: backlight, panel logic power, panel bias power enables.
// - standby request rising edge (standby function) starts power-down into standby.
// - suspend request debounced internally; high starts hardware suspend.
`timescale 1ns/10ps
`include "pm_defs.svh"
module lcd_power_mgmt_pins
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic [7:0] CTRL_I,
  input wire logic [7:0] STEP_DELAY_I,
  input wire logic STBY_FUNC_SEL_I,
  input wire logic SUSP_FUNC_SEL_I,
  input wire logic STANDBY_REQUEST_INPUT_I,
  input wire logic SUSPEND_REQUEST_INPUT_I,
  input wire logic SLEEP_N_I,
  input wire logic SLOW_CLOCK_INPUT_I,
  input wire logic CHIP_ACCESS_I,
  output logic ACCESS_GRANT_O,
  output logic MEM_IF_EN_O,
  output logic IO_IF_EN_O,
  output logic GENERAL_LEVEL_OUTPUT_O,
  output logic STANDBY_STATUS_N_O,
  output logic SUSPEND_STATUS_N_O,
  output logic REFRESH_TICK_O,
  output logic PANEL_BACKLIGHT_ENABLE_O,
  output logic PANEL_LOGIC_POWER_ENABLE_O,
  output logic PANEL_BIAS_POWER_ENABLE_O
);
  import pm_pkg::*;

  // ****************************************
  // pin synchronisers: three flops, change accepted when 2nd and 3rd agree
  // ****************************************
  logic [2:0] s_slp_r, s_slp_nxt, s_sby_r, s_sby_nxt, s_sus_r, s_sus_nxt, s_clk_r, s_clk_nxt;
  logic slp_q_r, slp_q_nxt, sby_q_r, sby_q_nxt, sus_q_r, sus_q_nxt, clk_q_r, clk_q_nxt;

  always_comb
  begin
    s_slp_nxt = {s_slp_r[1:0], SLEEP_N_I};
    s_sby_nxt = {s_sby_r[1:0], STANDBY_REQUEST_INPUT_I};
    s_sus_nxt = {s_sus_r[1:0], SUSPEND_REQUEST_INPUT_I};
    s_clk_nxt = {s_clk_r[1:0], SLOW_CLOCK_INPUT_I};
    slp_q_nxt = (s_slp_r[1] == s_slp_r[2]) ? s_slp_r[2] : slp_q_r;
    sby_q_nxt = (s_sby_r[1] == s_sby_r[2]) ? s_sby_r[2] : sby_q_r;
    sus_q_nxt = (s_sus_r[1] == s_sus_r[2]) ? s_sus_r[2] : sus_q_r;
    clk_q_nxt = (s_clk_r[1] == s_clk_r[2]) ? s_clk_r[2] : clk_q_r;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      s_slp_r <= 3'h7;
      s_sby_r <= 3'h0;
      s_sus_r <= 3'h0;
      s_clk_r <= 3'h0;
      slp_q_r <= 1'b1;
      sby_q_r <= 1'b0;
      sus_q_r <= 1'b0;
      clk_q_r <= 1'b0;
    end
    else if (CE_I)
    begin
      s_slp_r <= s_slp_nxt;
      s_sby_r <= s_sby_nxt;
      s_sus_r <= s_sus_nxt;
      s_clk_r <= s_clk_nxt;
      slp_q_r <= slp_q_nxt;
      sby_q_r <= sby_q_nxt;
      sus_q_r <= sus_q_nxt;
      clk_q_r <= clk_q_nxt;
    end
  end

  // ****************************************
  // slow clock tick, suspend debounce, sequencer
  // ****************************************
  logic tick;
  logic [3:0] deb_cnt_r, deb_cnt_nxt;
  logic susp_r, susp_nxt;
  logic [7:0] dly_r, dly_nxt;
  logic clk_d_r;
  logic lvl_r, lvl_nxt;
  seq_state_t st_r, st_nxt;
  logic sby_d_r;
  logic sby_pend_r, sby_pend_nxt;
  localparam logic [7:0] CTRL_RESET_V = `CTRL_RESET;
  localparam logic CTRL_RESET_BIT = CTRL_RESET_V[`OUTPUT_LEVEL_BIT];

  // rising edge of the filtered slow clock is the time base
  assign tick = clk_q_r & ~clk_d_r;

  always_comb
  begin
    deb_cnt_nxt = deb_cnt_r;
    susp_nxt = susp_r;
    // debounce in slow ticks so contact bounce never toggles suspend
    if (!SUSP_FUNC_SEL_I)
    begin
      deb_cnt_nxt = 4'h0;
      susp_nxt = 1'b0;
    end
    else if (sus_q_r == susp_r)
      deb_cnt_nxt = 4'h0;
    else if (tick)
    begin
      if (deb_cnt_r == `DEBOUNCE_TICKS)
      begin
        susp_nxt = sus_q_r;
        deb_cnt_nxt = 4'h0;
      end
      else
        deb_cnt_nxt = deb_cnt_r + 4'h1;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    // a standby edge is held until the panel is fully down, or dropped once the request or its function goes low
    sby_pend_nxt = sby_pend_r | (STBY_FUNC_SEL_I & sby_q_r & ~sby_d_r);
    if (!sby_q_r || !STBY_FUNC_SEL_I)
      sby_pend_nxt = 1'b0;
    lvl_nxt = CTRL_I[`OUTPUT_LEVEL_BIT];
    if (tick && dly_r != 8'h00)
      dly_nxt = dly_r - 8'h1;
    case (st_r)
      PWR_OFF:
        if (!susp_r && !sby_pend_r)
        begin
          st_nxt = PWR_LOGIC;
          dly_nxt = STEP_DELAY_I;
        end
      PWR_LOGIC:
        if (susp_r || sby_pend_r)
          st_nxt = PWR_DN_LOGIC;
        else if (dly_r == 8'h00)
        begin
          st_nxt = PWR_BIAS;
          dly_nxt = STEP_DELAY_I;
        end
      PWR_BIAS:
        if (susp_r || sby_pend_r)
          st_nxt = PWR_DN_BIAS;
        else if (dly_r == 8'h00)
          st_nxt = PWR_ON;
      PWR_ON:
        if (susp_r || sby_pend_r)
        begin
          st_nxt = PWR_DN_BIAS;
          dly_nxt = STEP_DELAY_I;
        end
      PWR_DN_BIAS:
        if (dly_r == 8'h00)
        begin
          st_nxt = PWR_DN_LOGIC;
          dly_nxt = STEP_DELAY_I;
        end
      PWR_DN_LOGIC:
        if (dly_r == 8'h00)
          st_nxt = sby_pend_r ? PWR_STBY : PWR_OFF;
      PWR_STBY:
        if (!sby_q_r || !STBY_FUNC_SEL_I)
          st_nxt = PWR_OFF;
      default:
        st_nxt = PWR_OFF;
    endcase
    if (st_r == PWR_DN_LOGIC && dly_r == 8'h00 && sby_pend_r)
      sby_pend_nxt = 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      deb_cnt_r <= 4'h0;
      susp_r <= 1'b0;
      dly_r <= `STEP_DELAY_RESET;
      clk_d_r <= 1'b0;
      lvl_r <= CTRL_RESET_BIT;
      st_r <= PWR_OFF;
      sby_d_r <= 1'b0;
      sby_pend_r <= 1'b0;
    end
    else if (CE_I)
    begin
      deb_cnt_r <= deb_cnt_nxt;
      susp_r <= susp_nxt;
      dly_r <= dly_nxt;
      clk_d_r <= clk_q_r;
      lvl_r <= lvl_nxt;
      st_r <= st_nxt;
      sby_d_r <= sby_q_r;
      sby_pend_r <= sby_pend_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign GENERAL_LEVEL_OUTPUT_O = lvl_r;
  assign STANDBY_STATUS_N_O = ~(st_r == PWR_STBY);
  assign SUSPEND_STATUS_N_O = ~(susp_r && st_r == PWR_OFF);
  // refresh is paced by the slow clock only while suspended
  assign REFRESH_TICK_O = tick & susp_r & (st_r == PWR_OFF);
  assign PANEL_LOGIC_POWER_ENABLE_O = (st_r != PWR_OFF) && (st_r != PWR_STBY);
  assign PANEL_BIAS_POWER_ENABLE_O = (st_r == PWR_BIAS) || (st_r == PWR_ON)
    || (st_r == PWR_DN_BIAS);
  assign PANEL_BACKLIGHT_ENABLE_O = (st_r == PWR_ON);
  assign MEM_IF_EN_O = slp_q_r;
  assign IO_IF_EN_O = slp_q_r;
  // filtered level and stages 2 and 3: access is refused once the low reaches stage 2, before the filtered level falls
  assign ACCESS_GRANT_O = CHIP_ACCESS_I & slp_q_r & s_slp_r[1] & s_slp_r[2];
endmodule

// [pm_defs.svh]
// timing counts, field positions and reset values for the panel power sequencer
`ifndef PM_DEFS_SVH
`define PM_DEFS_SVH
`define OUTPUT_LEVEL_BIT 7
`define CTRL_RESET 8'h00
`define DEBOUNCE_TICKS 4'h3
`define STEP_DELAY_RESET 8'h04
`endif

// [pm_pkg.sv]
// types shared by the power-management pin logic
package pm_pkg;
  typedef enum logic [2:0] {
    PWR_OFF = 3'b000,
    PWR_LOGIC = 3'b001,
    PWR_BIAS = 3'b011,
    PWR_ON = 3'b010,
    PWR_DN_BIAS = 3'b110,
    PWR_DN_LOGIC = 3'b111,
    PWR_STBY = 3'b101
  } seq_state_t;
endpackage

// [lcd_power_mgmt_pins_assertions.sv]
// concurrent checks on the power-management pin logic ports
`timescale 1ns/10ps
module lcd_power_mgmt_pins_chk (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic [7:0] CTRL_I,
  input wire logic SLEEP_N_I,
  input wire logic CHIP_ACCESS_I,
  input wire logic ACCESS_GRANT_O,
  input wire logic MEM_IF_EN_O,
  input wire logic IO_IF_EN_O,
  input wire logic GENERAL_LEVEL_OUTPUT_O,
  input wire logic STANDBY_STATUS_N_O,
  input wire logic SUSPEND_STATUS_N_O,
  input wire logic REFRESH_TICK_O,
  input wire logic PANEL_BACKLIGHT_ENABLE_O,
  input wire logic PANEL_LOGIC_POWER_ENABLE_O,
  input wire logic PANEL_BIAS_POWER_ENABLE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  level_follow_a: assert property (CE_I |=> GENERAL_LEVEL_OUTPUT_O == $past(CTRL_I[7]))
    else $error("level output does not follow control bit");
  grant_cause_a: assert property (ACCESS_GRANT_O |-> CHIP_ACCESS_I)
    else $error("grant without request");
  sleep_blocks_a: assert property (!SLEEP_N_I [*4] |-> !ACCESS_GRANT_O)
    else $error("access granted while asleep");
  sleep_ifs_a: assert property (!SLEEP_N_I [*6] |-> !MEM_IF_EN_O && !IO_IF_EN_O)
    else $error("interfaces enabled while asleep");
  ifs_pair_a: assert property (MEM_IF_EN_O == IO_IF_EN_O)
    else $error("memory and io enables differ");
  wake_ifs_a: assert property (SLEEP_N_I [*6] |-> MEM_IF_EN_O && IO_IF_EN_O)
    else $error("interfaces disabled while awake");
  stby_dark_a: assert property (!STANDBY_STATUS_N_O |-> !PANEL_LOGIC_POWER_ENABLE_O)
    else $error("panel powered in standby");
  susp_dark_a: assert property (!SUSPEND_STATUS_N_O |-> !PANEL_LOGIC_POWER_ENABLE_O)
    else $error("panel powered in suspend");
  bias_order_a: assert property (PANEL_BIAS_POWER_ENABLE_O |-> PANEL_LOGIC_POWER_ENABLE_O)
    else $error("bias without logic power");
  light_order_a: assert property (PANEL_BACKLIGHT_ENABLE_O |-> PANEL_BIAS_POWER_ENABLE_O)
    else $error("backlight without bias");
  tick_pulse_a: assert property (REFRESH_TICK_O |=> !REFRESH_TICK_O)
    else $error("refresh tick longer than one cycle");
endmodule
bind lcd_power_mgmt_pins lcd_power_mgmt_pins_chk i_chk (.*);

// [lcd_pm_partner.sv]
// system side model: free-running slow clock, a rising edge every 16 fast cycles
`timescale 1ns/10ps
module lcd_pm_partner (
  output logic slow_clk_o
);
  initial
  begin
    slow_clk_o = 1'b0;
    forever #32 slow_clk_o = ~slow_clk_o;
  end
endmodule

// [lcd_power_mgmt_pins_tb.sv]
// self-checking bench for the power-management pin logic
`timescale 1ns/10ps
module lcd_power_mgmt_pins_tb;
  logic clk = 0, rstn = 0, ce = 1, sbf = 0, suf = 1, sby = 0, sus = 0, slp = 1, acc = 1;
  logic [7:0] ctrl = 8'h00;
  logic [7:0] dly = 8'h01;
  logic slow, gnt, mem, io, lvl, sbn, sun, tick, bl, bias, lg;
  logic [4:0] vec, last = 5'b11000;
  logic [4:0] expq[$];
  int err_count = 0, n_compared = 0, n;
  assign vec = {sbn, sun, bl, bias, lg};
  initial forever #2 clk = ~clk;
  lcd_pm_partner i_far (.slow_clk_o(slow));
  lcd_power_mgmt_pins i_dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .CTRL_I(ctrl),
    .STEP_DELAY_I(dly), .STBY_FUNC_SEL_I(sbf), .SUSP_FUNC_SEL_I(suf),
    .STANDBY_REQUEST_INPUT_I(sby), .SUSPEND_REQUEST_INPUT_I(sus), .SLEEP_N_I(slp),
    .SLOW_CLOCK_INPUT_I(slow), .CHIP_ACCESS_I(acc), .ACCESS_GRANT_O(gnt),
    .MEM_IF_EN_O(mem), .IO_IF_EN_O(io), .GENERAL_LEVEL_OUTPUT_O(lvl),
    .STANDBY_STATUS_N_O(sbn), .SUSPEND_STATUS_N_O(sun), .REFRESH_TICK_O(tick),
    .PANEL_BACKLIGHT_ENABLE_O(bl), .PANEL_LOGIC_POWER_ENABLE_O(lg),
    .PANEL_BIAS_POWER_ENABLE_O(bias));
  task automatic check(string nm, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_vec(logic [4:0] e);
    for (int i = 0; i < 2000 && vec !== e; i++) @(negedge clk);
    check("settle", {3'h0, vec}, {3'h0, e});
  endtask
  // every change of panel and status pins must match the oldest note
  always @(negedge clk)
    if (rstn && vec !== last)
    begin
      last = vec;
      check("panel", {3'h0, vec}, expq.size() ? {3'h0, expq.pop_front()} : 8'hxx);
    end
  initial
  begin
    #40000;
    err_count++;
    complete_run;
  end
  initial
  begin
    void'($urandom(32'hf6204331));
    expq = '{5'b11001, 5'b11011, 5'b11111};
    repeat (2) @(negedge clk);
    rstn = 1;
    wait_vec(5'b11111);
    repeat (8)
    begin
      @(negedge clk) ctrl = 8'($urandom);
      @(negedge clk) check("level", {7'h0, lvl}, {7'h0, ctrl[7]});
    end
    // clock enable low must freeze the level register
    ce = 0;
    @(negedge clk) ctrl = ~ctrl;
    repeat (4) @(negedge clk);
    check("frozen", {7'h0, lvl}, {7'h0, ~ctrl[7]});
    ce = 1;
    @(negedge clk) check("thawed", {7'h0, lvl}, {7'h0, ctrl[7]});
    slp = 0;
    repeat (6) @(negedge clk);
    check("asleep", {5'h0, gnt, mem, io}, 8'h00);
    slp = 1;
    repeat (6) @(negedge clk);
    check("awake", {5'h0, gnt, mem, io}, 8'h07);
    acc = 0;
    @(negedge clk) check("idle", {7'h0, gnt}, 8'h00);
    acc = 1;
    // request with its function off must leave the panel alone
    sby = 1;
    repeat (100) @(negedge clk);
    sby = 0;
    sbf = 1;
    repeat (8) @(negedge clk);
    expq = '{5'b11011, 5'b11001, 5'b01000, 5'b11000, 5'b11001, 5'b11011, 5'b11111};
    sby = 1;
    wait_vec(5'b01000);
    sby = 0;
    wait_vec(5'b11111);
    // with its function off a long suspend request must leave the panel alone
    suf = 0;
    sus = 1;
    repeat (100) @(negedge clk);
    sus = 0;
    repeat (8) @(negedge clk);
    suf = 1;
    // one slow tick of suspend request is a bounce and is filtered out
    sus = 1;
    repeat (16) @(negedge clk);
    sus = 0;
    repeat (100) @(negedge clk);
    expq = '{5'b11011, 5'b11001, 5'b10000};
    sus = 1;
    wait_vec(5'b10000);
    n = 0;
    repeat (64) @(negedge clk) n += tick;
    check("ticks", 8'(n), 8'h04);
    check("pending", 8'(expq.size()), 8'h00);
    complete_run;
  end
endmodule
